// [shared/obc_pkg.sv]
// option byte security configuration constants and rule summary
// Function
// - configuration byte lives in the last flash location, selecting protection and options
// - configuration byte writable only in external or in-system programming mode
// - factory-shipped device reads the configuration byte as all zeros
// - bit 5 set blocks flash read/write except user ISP; mass erase allowed
// - bit 2 zero enables supervisor timer, its pin output with weak pull-up
// - bit 1 set prevents clock-stop mode entry
// - bit 0 set boots from flash, zero boots from boot ROM
// - protected external reads of program locations return all ones
// - protection rejects external program writes, option writes and page erases
// - alias address reads the configuration byte regardless of protection
// - mass erase always executes whatever the protection bit
// - protection bit cleared only by mass erase, except under user ISP
// - unprotected device returns true flash contents externally
// - configuration byte written once; rewrite refused until last page erased
// - initialization on external reset pin or brownout detector
// - during reset pins float, pins zero and two pulled up, supervisor pin per option; the code holds the supervisor pin off until config_valid
package obc_pkg;
	localparam logic [15:0] OPT_ADDR       = 16'h1fff; // physical option location
	localparam logic [15:0] OPT_ALIAS_ADDR = 16'hffff; // alias readable when secured
	localparam logic [7:0]  OPT_RESET      = 8'h00;    // factory value
	localparam logic [7:0]  ERASED_BYTE    = 8'h00;    // erased flash content
	localparam logic [7:0]  SECURED_BYTE   = 8'hff;    // value read when secured
	localparam logic [7:0]  RSVD_MASK      = 8'hd8;    // bits 7,6,4,3
	localparam int          BIT_SECURITY   = 5;
	localparam int          BIT_SUPERVISOR = 2;
	localparam int          BIT_CLKSTOP    = 1;
	localparam int          BIT_BOOT_FLASH = 0;
	localparam int          PAGE_BITS      = 6;        // 64-byte pages
	localparam int          ADDR_BITS      = 13;       // 8k flash
	localparam int          LOAD_CYCLES    = 2;        // flash sample latency at reset release

	typedef enum logic [2:0]
	{
		OBC_LOAD  = 3'b001,
		OBC_LATCH = 3'b010,
		OBC_RUN   = 3'b100
	} obc_state_e;
endpackage : obc_pkg

// [core/obc_flash_array.sv]
// flash array with byte program, page erase and mass erase
`timescale 1ns/10ps
module obc_flash_array #(
	parameter int ADDR_BITS = obc_pkg::ADDR_BITS,
	parameter int PAGE_BITS = obc_pkg::PAGE_BITS
) (
	input  wire logic                 clk,
	input  wire logic                 reset_n,
	input  wire logic [ADDR_BITS-1:0] rd_addr,
	output logic      [7:0]           rd_data,
	input  wire logic                 wr_en,
	input  wire logic [ADDR_BITS-1:0] wr_addr,
	input  wire logic [7:0]           wr_data,
	input  wire logic                 page_erase,
	input  wire logic                 mass_erase
);
	localparam int DEPTH = 1 << ADDR_BITS;
	localparam int PAGES = 1 << (ADDR_BITS - PAGE_BITS);

	initial
	begin
		if (PAGE_BITS >= ADDR_BITS || ADDR_BITS > 16)
			$error("obc_flash_array: unsupported geometry");
	end

	// flash leaves the factory erased; contents then persist across every reset
	logic [7:0] mem_reg [DEPTH] = '{default: obc_pkg::ERASED_BYTE};
	wire  [ADDR_BITS-PAGE_BITS-1:0] wr_page = wr_addr[ADDR_BITS-1:PAGE_BITS];

	// one process per byte; erase wins over program, leaving bytes at the erased value
	genvar i;
	generate
		for (i = 0; i < DEPTH; i++)
		begin : g_byte
			localparam logic [ADDR_BITS-1:0] LOC = ADDR_BITS'(i);
			wire                             hit_page = (wr_page == LOC[ADDR_BITS-1:PAGE_BITS]);
			// no reset branch: cells are nonvolatile, so a reset must not touch them
			always_ff @(posedge clk)
			begin
				if (mass_erase || (page_erase && hit_page))
					mem_reg[i] <= obc_pkg::ERASED_BYTE;
				else if (wr_en && wr_addr == LOC)
					mem_reg[i] <= mem_reg[i] | wr_data; // programming only sets bits
			end
		end
	endgenerate

	// registered read port
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			rd_data <= 8'h00;
		else
			rd_data <= mem_reg[rd_addr];
	end
endmodule : obc_flash_array

// [core/obc_option_byte_security_config.sv]
// option byte decoder and flash access guard
`timescale 1ns/10ps
module obc_option_byte_security_config #(
	parameter int ADDR_BITS = obc_pkg::ADDR_BITS
) (
	input  wire logic        clk,
	input  wire logic        reset_n,
	input  wire logic        brownout,
	input  wire logic        ext_prog_mode,
	input  wire logic        isp_prog_mode,
	input  wire logic        user_isp,
	input  wire logic        req_valid,
	input  wire logic [1:0]  req_op,
	input  wire logic [15:0] req_addr,
	input  wire logic [7:0]  req_wdata,
	output logic             resp_valid,
	output logic [7:0]       resp_rdata,
	output logic             resp_refused,
	output logic [7:0]       config_option_byte,
	output logic             security_on,
	output logic             supervisor_enable,
	output logic             clock_stop_allowed,
	output logic             boot_from_flash,
	output logic             config_valid,
	input  wire logic        supervisor_drive,
	output logic             supervisor_out_pin_level,
	output logic             supervisor_out_pin_oe,
	output logic             supervisor_out_pin_pu,
	output logic             port_g_pin_zero_pu,
	output logic             port_g_pin_two_pu,
	output logic             port_pins_oe,
	output logic             in_reset
);
	// request operation codes
	localparam logic [1:0] OP_READ  = 2'h0;
	localparam logic [1:0] OP_WRITE = 2'h1;
	localparam logic [1:0] OP_PAGE  = 2'h2;
	localparam logic [1:0] OP_MASS  = 2'h3;

	initial
	begin
		if (ADDR_BITS != obc_pkg::ADDR_BITS)
			$error("obc: option location assumes the documented flash size");
	end

	// brownout is asynchronous to clk: two flops before use
	logic bo_meta_reg;
	logic bo_sync_reg;
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			bo_meta_reg <= 1'b1;
			bo_sync_reg <= 1'b1;
		end
		else
		begin
			bo_meta_reg <= brownout;
			bo_sync_reg <= bo_meta_reg;
		end
	end

	// program mode straps also come from pins
	logic [2:0] mode_meta_reg;
	logic [2:0] mode_sync_reg;
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			mode_meta_reg <= 3'h0;
			mode_sync_reg <= 3'h0;
		end
		else
		begin
			mode_meta_reg <= {user_isp, isp_prog_mode, ext_prog_mode};
			mode_sync_reg <= mode_meta_reg;
		end
	end
	wire ext_mode_s  = mode_sync_reg[0];
	wire isp_mode_s  = mode_sync_reg[1];
	wire user_isp_s  = mode_sync_reg[2];
	wire prog_mode_s = ext_mode_s | isp_mode_s;

	// sequencer: either reset source sends the block back to load the option byte
	obc_pkg::obc_state_e state_reg;
	obc_pkg::obc_state_e state_next;
	logic [1:0]          load_cnt_reg;
	wire                 reload = bo_sync_reg;

	always_comb
	begin
		state_next = state_reg;
		unique case (state_reg)
			obc_pkg::OBC_LOAD:  if (load_cnt_reg == 2'(obc_pkg::LOAD_CYCLES - 1))
					state_next = obc_pkg::OBC_LATCH;
			obc_pkg::OBC_LATCH: state_next = obc_pkg::OBC_RUN;
			obc_pkg::OBC_RUN:   state_next = obc_pkg::OBC_RUN;
			default:            state_next = obc_pkg::OBC_LOAD;
		endcase
		if (reload)
			state_next = obc_pkg::OBC_LOAD;
	end

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			state_reg <= obc_pkg::OBC_LOAD;
		else
			state_reg <= state_next;
	end

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			load_cnt_reg <= 2'h0;
		else if (state_reg != obc_pkg::OBC_LOAD || reload)
			load_cnt_reg <= 2'h0; // a held reload restarts the load count from zero
		else
			load_cnt_reg <= load_cnt_reg + 2'h1;
	end

	wire running  = (state_reg == obc_pkg::OBC_RUN);
	wire latching = (state_reg == obc_pkg::OBC_LATCH);

	// flash port sharing: loader reads the option location, otherwise the request does
	wire [ADDR_BITS-1:0] opt_loc   = obc_pkg::OPT_ADDR[ADDR_BITS-1:0];
	wire                 is_alias  = (req_addr == obc_pkg::OPT_ALIAS_ADDR);
	wire                 is_opt    = (req_addr == obc_pkg::OPT_ADDR) | is_alias;
	wire                 addr_ok   = (req_addr[15:ADDR_BITS] == '0) | is_alias;
	wire [ADDR_BITS-1:0] req_loc   = is_alias ? opt_loc : req_addr[ADDR_BITS-1:0];
	wire [ADDR_BITS-1:0] rd_loc    = running ? req_loc : opt_loc;
	logic [7:0]          flash_rd;
	logic [7:0]          config_option_byte_raw; // live stored option, for the rewrite check

	// access policy: security from the latched option, rewrite check from the live stored copy
	wire sec          = security_on;
	wire take         = running & req_valid;
	wire is_rd        = take & (req_op == OP_READ);
	wire is_wr        = take & (req_op == OP_WRITE);
	wire is_pe        = take & (req_op == OP_PAGE);
	wire is_me        = take & (req_op == OP_MASS);
	wire sec_block    = sec & ~user_isp_s;
	wire opt_wr_allow = prog_mode_s & ~sec & (config_option_byte_raw == obc_pkg::ERASED_BYTE);
	wire wr_allow     = addr_ok & (is_opt ? opt_wr_allow : ~sec_block);
	wire pe_allow     = addr_ok & ~sec_block & (~is_opt | prog_mode_s);
	wire do_wr        = is_wr & wr_allow;
	wire do_pe        = is_pe & pe_allow;
	wire do_me        = is_me;
	wire refuse       = (is_wr & ~wr_allow) | (is_pe & ~pe_allow) | (is_rd & ~addr_ok);

	obc_flash_array #(
		.ADDR_BITS (ADDR_BITS),
		.PAGE_BITS (obc_pkg::PAGE_BITS)
	) u_flash (
		.clk        (clk),
		.reset_n    (reset_n),
		.rd_addr    (rd_loc),
		.rd_data    (flash_rd),
		.wr_en      (do_wr),
		.wr_addr    (req_loc),
		.wr_data    (req_wdata),
		.page_erase (do_pe),
		.mass_erase (do_me)
	);

	// live copy of the stored option byte, tracking program and erase effects
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			config_option_byte_raw <= obc_pkg::OPT_RESET;
		else if (latching)
			config_option_byte_raw <= flash_rd;
		else if (do_me || (do_pe && req_loc[ADDR_BITS-1:obc_pkg::PAGE_BITS]
				== opt_loc[ADDR_BITS-1:obc_pkg::PAGE_BITS]))
			config_option_byte_raw <= obc_pkg::ERASED_BYTE;
		else if (do_wr && is_opt)
			config_option_byte_raw <= req_wdata;
	end

	// decoded options are frozen at the load and held until the next reset
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			config_option_byte <= obc_pkg::OPT_RESET;
		else if (latching)
			config_option_byte <= flash_rd & ~obc_pkg::RSVD_MASK;
	end

	// security latched from stored flash at load; mass erase drops it at once
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			security_on <= 1'b0;
		else if (latching)
			security_on <= flash_rd[obc_pkg::BIT_SECURITY];
		else if (do_me)
			security_on <= 1'b0;
	end

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			config_valid <= 1'b0;
		else
			config_valid <= running | latching;
	end

	// option decode from the held byte
	assign supervisor_enable  = ~config_option_byte[obc_pkg::BIT_SUPERVISOR];
	assign clock_stop_allowed = ~config_option_byte[obc_pkg::BIT_CLKSTOP];
	assign boot_from_flash    = config_option_byte[obc_pkg::BIT_BOOT_FLASH];

	// read data: secured reads outside user ISP yield all ones except the option byte itself
	wire       rd_hide   = sec_block & ~is_opt;
	logic      rd_pend_reg;
	logic      rd_hide_reg;

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			rd_pend_reg <= 1'b0;
			rd_hide_reg <= 1'b0;
		end
		else
		begin
			rd_pend_reg <= is_rd & addr_ok;
			rd_hide_reg <= rd_hide;
		end
	end

	// answers: reads one cycle after the flash sample, others the next cycle
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			resp_valid   <= 1'b0;
			resp_rdata   <= 8'h00;
			resp_refused <= 1'b0;
		end
		else
		begin
			resp_valid   <= rd_pend_reg | (take & (req_op != OP_READ)) | (is_rd & ~addr_ok);
			resp_refused <= refuse;
			if (rd_pend_reg)
				resp_rdata <= rd_hide_reg ? obc_pkg::SECURED_BYTE : flash_rd;
			else
				resp_rdata <= 8'h00;
		end
	end

	// pins: port pins always float; pull-ups on pins zero and two while not running
	assign in_reset              = ~running;
	assign port_pins_oe          = 1'b0;
	assign port_g_pin_zero_pu    = in_reset;
	assign port_g_pin_two_pu     = in_reset;
	// open drain: the pin is driven only while the timer pulls it low
	assign supervisor_out_pin_oe    = config_valid & supervisor_enable & supervisor_drive;
	assign supervisor_out_pin_level = 1'b0;
	assign supervisor_out_pin_pu = config_valid & supervisor_enable;

endmodule : obc_option_byte_security_config

// [verification/obc_props.sv]
// concurrent checks on the option byte decoder ports
`timescale 1ns/10ps
module obc_props #(
	parameter int ADDR_BITS = 13
) (
	input wire logic        clk,
	input wire logic        reset_n,
	input wire logic        ext_prog_mode,
	input wire logic        isp_prog_mode,
	input wire logic        user_isp,
	input wire logic        req_valid,
	input wire logic [1:0]  req_op,
	input wire logic [15:0] req_addr,
	input wire logic        resp_valid,
	input wire logic [7:0]  resp_rdata,
	input wire logic        resp_refused,
	input wire logic        security_on,
	input wire logic        supervisor_enable,
	input wire logic        clock_stop_allowed,
	input wire logic        boot_from_flash,
	input wire logic        supervisor_out_pin_oe,
	input wire logic        supervisor_out_pin_pu,
	input wire logic        port_g_pin_zero_pu,
	input wire logic        port_g_pin_two_pu,
	input wire logic        port_pins_oe,
	input wire logic        in_reset
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);
	// request decode shared by the checks
	wire taken    = req_valid && !in_reset;
	wire in_flash = (req_addr >> ADDR_BITS) == 16'h0000;
	wire plain    = in_flash && req_addr != obc_pkg::OPT_ADDR;
	AST_SECURED_READ_FF: assert property (
		taken && req_op == 2'h0 && plain && security_on && !user_isp
		|-> ##2 resp_valid && resp_rdata == 8'hff) else $error("secured read leaked data");
	AST_ALIAS_READ: assert property (
		taken && req_op == 2'h0 && req_addr == obc_pkg::OPT_ALIAS_ADDR
		|-> ##2 resp_valid && !resp_refused) else $error("alias read refused");
	AST_SECURED_WRITE_REFUSED: assert property (
		taken && req_op inside {2'h1, 2'h2} && security_on && !user_isp
		|=> resp_valid && resp_refused) else $error("secured write or erase accepted");
	AST_MASS_ERASE: assert property (
		taken && req_op == 2'h3 && in_flash
		|=> resp_valid && !resp_refused && !security_on) else $error("mass erase failed");
	AST_OPT_WRITE_MODE: assert property (
		(!ext_prog_mode && !isp_prog_mode)[*4] ##0
		(taken && req_op == 2'h1 && req_addr == obc_pkg::OPT_ADDR)
		|=> resp_valid && resp_refused) else $error("option written outside programming");
	AST_OPTIONS_HELD: assert property (
		!in_reset && !$past(in_reset) |-> $stable(supervisor_enable)
		&& $stable(clock_stop_allowed) && $stable(boot_from_flash)) else $error("options moved");
	AST_NO_SECURE_IN_RUN: assert property (
		!in_reset && !$past(in_reset) && !$past(security_on) |-> !security_on)
		else $error("security set while running");
	AST_RESET_PINS: assert property (
		in_reset |-> port_g_pin_zero_pu && port_g_pin_two_pu && !port_pins_oe)
		else $error("pins wrong during reset");
	AST_SUP_OFF: assert property (
		!supervisor_enable |-> !supervisor_out_pin_oe && !supervisor_out_pin_pu)
		else $error("supervisor pin active while disabled");
	// main scenarios reached
	cover property (taken && req_op == 2'h3);
	cover property (taken && security_on && req_op == 2'h0);
	cover property (resp_valid && resp_refused);
endmodule : obc_props

bind obc_option_byte_security_config obc_props #(.ADDR_BITS(ADDR_BITS)) u_props (
	.clk(clk), .reset_n(reset_n), .ext_prog_mode(ext_prog_mode),
	.isp_prog_mode(isp_prog_mode), .user_isp(user_isp), .req_valid(req_valid),
	.req_op(req_op), .req_addr(req_addr), .resp_valid(resp_valid),
	.resp_rdata(resp_rdata), .resp_refused(resp_refused), .security_on(security_on),
	.supervisor_enable(supervisor_enable), .clock_stop_allowed(clock_stop_allowed),
	.boot_from_flash(boot_from_flash), .supervisor_out_pin_oe(supervisor_out_pin_oe),
	.supervisor_out_pin_pu(supervisor_out_pin_pu), .port_g_pin_zero_pu(port_g_pin_zero_pu),
	.port_g_pin_two_pu(port_g_pin_two_pu), .port_pins_oe(port_pins_oe), .in_reset(in_reset));

// [verification/obc_prog_host.sv]
// programmer-side model issuing flash requests
`timescale 1ns/10ps
module obc_prog_host (
	input  wire logic        clk,
	input  wire logic        resp_valid,
	input  wire logic [7:0]  resp_rdata,
	input  wire logic        resp_refused,
	output logic             req_valid,
	output logic [1:0]       req_op,
	output logic [15:0]      req_addr,
	output logic [7:0]       req_wdata
);
	initial
	begin
		req_valid = 1'b0;
		req_op    = 2'h0;
		req_addr  = 16'h0000;
		req_wdata = 8'h00;
	end
	// one request pulse, then a bounded wait for its answer
	task automatic xfer(input logic [1:0] op, input logic [15:0] a, input logic [7:0] d,
		output logic rf, output logic [7:0] rd);
		int         n;
		logic [7:0] wd;
		wd = (a == obc_pkg::OPT_ADDR) ? ((d & ~obc_pkg::RSVD_MASK) | 8'h01) : d;
		@(posedge clk);
		req_valid <= 1'b1;
		req_op    <= op;
		req_addr  <= a;
		req_wdata <= wd;
		@(posedge clk);
		req_valid <= 1'b0;
		req_op    <= ~op; // released lines never keep the last value
		req_addr  <= ~a;
		req_wdata <= ~wd;
		n = 0;
		#1;
		while (resp_valid !== 1'b1 && n < 4)
		begin
			@(posedge clk);
			#1;
			n++;
		end
		rf = (n == 4) ? 1'bx : resp_refused;
		rd = (n == 4) ? 8'hxx : resp_rdata;
	endtask : xfer
endmodule : obc_prog_host

// [verification/tb_top.sv]
// self-checking bench for the option byte decoder
`timescale 1ns/10ps
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin n_fail++; \
	$display("unexpected %s expected %h seen %h", nm, e, g); end end
module tb_top;
	logic        clk, reset_n, brownout, ext_prog_mode, isp_prog_mode, user_isp, drv;
	logic        req_valid, resp_valid, resp_refused, rf, sec, sup, cst, boot, cval;
	logic        s_o, s_oe, s_pu, pu0, pu2, p_oe, in_rst;
	logic [1:0]  req_op;
	logic [15:0] req_addr;
	logic [7:0]  req_wdata, resp_rdata, cfg, rd;
	int          n_fail, comparisons;
	obc_option_byte_security_config uut (.clk(clk), .reset_n(reset_n), .brownout(brownout),
		.ext_prog_mode(ext_prog_mode), .isp_prog_mode(isp_prog_mode), .user_isp(user_isp),
		.req_valid(req_valid), .req_op(req_op), .req_addr(req_addr), .req_wdata(req_wdata),
		.resp_valid(resp_valid), .resp_rdata(resp_rdata), .resp_refused(resp_refused),
		.config_option_byte(cfg), .security_on(sec), .supervisor_enable(sup),
		.clock_stop_allowed(cst), .boot_from_flash(boot), .config_valid(cval),
		.supervisor_drive(drv), .supervisor_out_pin_level(s_o), .supervisor_out_pin_oe(s_oe),
		.supervisor_out_pin_pu(s_pu), .port_g_pin_zero_pu(pu0), .port_g_pin_two_pu(pu2),
		.port_pins_oe(p_oe), .in_reset(in_rst));
	obc_prog_host host (.clk(clk), .resp_valid(resp_valid), .resp_rdata(resp_rdata),
		.resp_refused(resp_refused), .req_valid(req_valid), .req_op(req_op),
		.req_addr(req_addr), .req_wdata(req_wdata));
	// 10 MHz clock
	initial
	begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	task close_out;
		if (n_fail == 0 && comparisons > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : close_out
	// factory state decode, reset pin levels and supervisor pin
	task t_defaults;
		`CHK("pu_zero", 1'b1, pu0)
		`CHK("pu_two", 1'b1, pu2)
		`CHK("pins_oe", 1'b0, p_oe)
		reset_n <= 1'b1;
		repeat (8) @(posedge clk);
		`CHK("option", 8'h00, cfg)
		`CHK("valid", 1'b1, cval)
		`CHK("boot", 1'b0, boot)
		`CHK("clkstop", 1'b1, cst)
		`CHK("sup_en", 1'b1, sup)
		host.xfer(2'h0, obc_pkg::OPT_ALIAS_ADDR, 8'h00, rf, rd);
		`CHK("alias", 8'h00, rd)
		drv <= 1'b1;
		repeat (4) @(posedge clk);
		`CHK("sup_oe", 1'b1, s_oe)
		`CHK("sup_pu", 1'b1, s_pu)
		`CHK("sup_level", 1'b0, s_o)
	endtask : t_defaults
	// option write without a programming mode
	task t_outside;
		host.xfer(2'h1, obc_pkg::OPT_ADDR, 8'h25, rf, rd);
		`CHK("opt_refused", 1'b1, rf)
	endtask : t_outside
	// programming mode: data, option once, refused rewrite
	task t_program;
		ext_prog_mode <= 1'b1;
		repeat (4) @(posedge clk);
		host.xfer(2'h1, 16'h0010, 8'h55, rf, rd);
		`CHK("wr_ok", 1'b0, rf)
		host.xfer(2'h0, 16'h0010, 8'h00, rf, rd);
		`CHK("rd_true", 8'h55, rd)
		host.xfer(2'h1, obc_pkg::OPT_ADDR, 8'h25, rf, rd);
		`CHK("opt_ok", 1'b0, rf)
		host.xfer(2'h1, obc_pkg::OPT_ADDR, 8'h27, rf, rd);
		`CHK("rewrite", 1'b1, rf)
		host.xfer(2'h0, obc_pkg::OPT_ALIAS_ADDR, 8'h00, rf, rd);
		`CHK("alias_new", 8'h25, rd)
		`CHK("sec_held", 1'b0, sec)
	endtask : t_program
	// brownout reload brings the secured options in
	task t_secured;
		brownout <= 1'b1;
		repeat (4) @(posedge clk);
		brownout <= 1'b0;
		repeat (12) @(posedge clk);
		`CHK("sec_on", 1'b1, sec)
		`CHK("sup_off", 1'b0, sup)
		`CHK("sup_oe_off", 1'b0, s_oe)
		`CHK("clkstop2", 1'b1, cst)
		`CHK("boot2", 1'b1, boot)
		host.xfer(2'h0, 16'h0010, 8'h00, rf, rd);
		`CHK("rd_ff", 8'hff, rd)
		host.xfer(2'h0, obc_pkg::OPT_ADDR, 8'h00, rf, rd);
		`CHK("rd_opt", 8'h25, rd)
		host.xfer(2'h0, obc_pkg::OPT_ALIAS_ADDR, 8'h00, rf, rd);
		`CHK("alias_sec", 8'h25, rd)
		host.xfer(2'h1, 16'h0010, 8'h0f, rf, rd);
		`CHK("wr_block", 1'b1, rf)
		host.xfer(2'h2, 16'h0000, 8'h00, rf, rd);
		`CHK("pe_block", 1'b1, rf)
		user_isp <= 1'b1;
		repeat (4) @(posedge clk);
		host.xfer(2'h0, 16'h0010, 8'h00, rf, rd);
		`CHK("rd_user_isp", 8'h55, rd)
		user_isp <= 1'b0;
		repeat (4) @(posedge clk);
	endtask : t_secured
	// mass erase wins over security
	task t_erase;
		host.xfer(2'h3, 16'h0000, 8'h00, rf, rd);
		`CHK("me_ok", 1'b0, rf)
		`CHK("sec_clear", 1'b0, sec)
		host.xfer(2'h0, 16'h0010, 8'h00, rf, rd);
		`CHK("erased", obc_pkg::ERASED_BYTE, rd)
	endtask : t_erase
	// hang guard
	initial
	begin
		#400000;
		n_fail++;
		close_out;
	end
	initial
	begin
		n_fail = 0;
		comparisons = 0;
		reset_n = 1'b0;
		brownout = 1'b0;
		ext_prog_mode = 1'b0;
		isp_prog_mode = 1'b0;
		user_isp = 1'b0;
		drv = 1'b0;
		repeat (16) @(posedge clk);
		t_defaults;
		t_outside;
		t_program;
		t_secured;
		t_erase;
		close_out;
	end
endmodule : tb_top
